// ==== inc/dmb_defs.svh ====
// Offsets, field positions, reset values and cycle counts of the data-move and bit unit
`ifndef DMB_DEFS_SVH
`define DMB_DEFS_SVH
`define DMB_OFS_CMD   16'h0000
`define DMB_OFS_ARG   16'h0004
`define DMB_OFS_STAT  16'h0008
`define DMB_OFS_SP    16'h000c
`define DMB_OFS_GPR   16'h0100
`define DMB_OFS_IO    16'h0200
`define DMB_OFS_DMEM  16'h1000
`define DMB_STAT_BUSY 8
`define DMB_FLAG_C    0
`define DMB_FLAG_Z    1
`define DMB_FLAG_N    2
`define DMB_FLAG_V    3
`define DMB_FLAG_T    6
`define DMB_PTR_X_LO  5'h1a
`define DMB_PTR_Y_LO  5'h1c
`define DMB_PTR_Z_LO  5'h1e
`define DMB_SP_RST    16'h007f
`define DMB_STAT_RST  8'h00
`define DMB_CYC_MEM   2
`define DMB_CYC_ALU   1
`endif

// ==== inc/dmb_pkg.sv ====
// Types of the data-move and bit unit
package dmb_pkg;
  typedef enum logic [4:0] {
    OP_NOP                = 5'h00,
    OP_LOAD_INDIRECT      = 5'h01,
    OP_LOAD_OFFSET        = 5'h02,
    OP_LOAD_ABSOLUTE      = 5'h03,
    OP_SAVE_VIA_POINTER   = 5'h04,
    OP_SAVE_OFFSET        = 5'h05,
    OP_SAVE_ABSOLUTE      = 5'h06,
    OP_STACK_PUT          = 5'h07,
    OP_STACK_TAKE         = 5'h08,
    OP_IO_BIT_RAISE       = 5'h09,
    OP_IO_BIT_DROP        = 5'h0a,
    OP_SHIFT_UP_LOGICAL   = 5'h0b,
    OP_SHIFT_DOWN_LOGICAL = 5'h0c,
    OP_ROTATE_UP_CARRY    = 5'h0d,
    OP_ROTATE_DOWN_CARRY  = 5'h0e,
    OP_SHIFT_DOWN_SIGNED  = 5'h0f,
    OP_NIBBLE_SWAP        = 5'h10,
    OP_FLAG_CAPTURE_BIT   = 5'h11,
    OP_FLAG_DEPOSIT_BIT   = 5'h12
  } dmb_op_t;
  typedef enum logic [1:0] {PTR_X = 2'b00, PTR_Y = 2'b01, PTR_Z = 2'b10} dmb_ptr_t;
  typedef enum logic [1:0] {MODE_PLAIN = 2'b00, MODE_POST_INC = 2'b01, MODE_PRE_DEC = 2'b10} dmb_mode_t;
  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_EX1 = 2'b01, ST_EX2 = 2'b10} dmb_state_t;
  // Ordered so that {ARG[15:0], CMD[22:0]} maps straight onto it
  typedef struct packed {
    logic [15:0] addr;
    logic [5:0]  disp;
    dmb_mode_t   mode;
    dmb_ptr_t    ptr;
    logic [2:0]  bsel;
    logic [4:0]  rsel;
    dmb_op_t     op;
  } dmb_cmd_t;
endpackage

// ==== hdl/dmb_core.sv ====
// Data-move, shift and bit execution unit with Avalon-MM register access
//
// The register offsets and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/100ps
`include "dmb_defs.svh"
module dmb_core #(
  parameter int DMEM_DEPTH = 128,
  parameter int IO_DEPTH   = 64,
  parameter int NREG       = 32
) (
  input  wire logic        clk,             // 125 MHz core clock
  input  wire logic        rst_b,           // Synchronous reset, active low
  input  wire logic [15:0] avs_address,     // Byte address
  input  wire logic        avs_read,        // Read request
  input  wire logic        avs_write,       // Write request
  input  wire logic [31:0] avs_writedata,   // Write data
  input  wire logic [3:0]  avs_byteenable,  // Byte lanes
  output logic      [31:0] avs_readdata,    // Read data, registered
  output logic             avs_waitrequest  // Stall, registered
);
  localparam int DAW = $clog2(DMEM_DEPTH);
  localparam int IOW = $clog2(IO_DEPTH);
  localparam int RW  = $clog2(NREG);

  logic [7:0]  gpr_q [NREG];
  logic [7:0]  dmem_q [DMEM_DEPTH];
  logic [7:0]  io_q [IO_DEPTH];
  logic [7:0]  status_q;
  logic [15:0] sp_q;
  logic [31:0] cmd_raw_q, arg_raw_q, rdata_q, rd_mux;
  logic        wait_q;
  dmb_pkg::dmb_state_t state_q;
  dmb_pkg::dmb_cmd_t   cmd;

  assign cmd = dmb_pkg::dmb_cmd_t'({arg_raw_q[15:0], cmd_raw_q[22:0]});
  assign avs_readdata    = rdata_q;
  assign avs_waitrequest = wait_q;

  // Bus decode; every access stalls while an operation runs
  logic req, wr, hit_gpr, hit_io, hit_dmem;
  logic [15:0] ofs_gpr, ofs_io, ofs_dmem;
  assign req      = (avs_read | avs_write) & wait_q & (state_q == dmb_pkg::ST_IDLE);
  assign wr       = req & avs_write;
  assign ofs_gpr  = avs_address - `DMB_OFS_GPR;
  assign ofs_io   = avs_address - `DMB_OFS_IO;
  assign ofs_dmem = avs_address - `DMB_OFS_DMEM;
  assign hit_gpr  = (avs_address >= `DMB_OFS_GPR) && (ofs_gpr < 16'(4 * NREG));
  assign hit_io   = (avs_address >= `DMB_OFS_IO) && (ofs_io < 16'(4 * IO_DEPTH));
  assign hit_dmem = (avs_address >= `DMB_OFS_DMEM) && (ofs_dmem < 16'(4 * DMEM_DEPTH));

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (avs_address == `DMB_OFS_CMD) begin
      rd_mux = cmd_raw_q;
    end else if (avs_address == `DMB_OFS_ARG) begin
      rd_mux = arg_raw_q;
    end else if (avs_address == `DMB_OFS_STAT) begin
      rd_mux = {23'h0, state_q != dmb_pkg::ST_IDLE, status_q};
    end else if (avs_address == `DMB_OFS_SP) begin
      rd_mux = {16'h0, sp_q};
    end else if (hit_gpr) begin
      rd_mux = {24'h0, gpr_q[ofs_gpr[RW+1:2]]};
    end else if (hit_io) begin
      rd_mux = {24'h0, io_q[ofs_io[IOW+1:2]]};
    end else if (hit_dmem) begin
      rd_mux = {24'h0, dmem_q[ofs_dmem[DAW+1:2]]};
    end
  end

  // Answer one cycle after the request is taken, then rearm
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wait_q  <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else if (req) begin
      wait_q  <= 1'b0;
      rdata_q <= avs_read ? rd_mux : 32'h0000_0000;
    end else begin
      wait_q  <= 1'b1;
    end
  end

  logic launch;
  assign launch = wr && (avs_address == `DMB_OFS_CMD) && (|avs_byteenable);

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cmd_raw_q <= 32'h0000_0000;
      arg_raw_q <= 32'h0000_0000;
    end else if (wr) begin
      for (int i = 0; i < 4; i++) begin
        if (avs_byteenable[i] && avs_address == `DMB_OFS_CMD) cmd_raw_q[i*8 +: 8] <= avs_writedata[i*8 +: 8];
        if (avs_byteenable[i] && avs_address == `DMB_OFS_ARG) arg_raw_q[i*8 +: 8] <= avs_writedata[i*8 +: 8];
      end
    end
  end

  // Operation decode
  logic is_load, is_store, is_ptr, is_alu, is_flag_op, two_cyc, pre_dec, post_inc;
  always_comb begin
    is_load    = cmd.op inside {dmb_pkg::OP_LOAD_INDIRECT, dmb_pkg::OP_LOAD_OFFSET, dmb_pkg::OP_LOAD_ABSOLUTE,
                                dmb_pkg::OP_STACK_TAKE};
    is_store   = cmd.op inside {dmb_pkg::OP_SAVE_VIA_POINTER, dmb_pkg::OP_SAVE_OFFSET, dmb_pkg::OP_SAVE_ABSOLUTE,
                                dmb_pkg::OP_STACK_PUT};
    is_ptr     = cmd.op inside {dmb_pkg::OP_LOAD_INDIRECT, dmb_pkg::OP_SAVE_VIA_POINTER};
    is_flag_op = cmd.op inside {dmb_pkg::OP_SHIFT_UP_LOGICAL, dmb_pkg::OP_SHIFT_DOWN_LOGICAL,
                                dmb_pkg::OP_ROTATE_UP_CARRY, dmb_pkg::OP_ROTATE_DOWN_CARRY,
                                dmb_pkg::OP_SHIFT_DOWN_SIGNED};
    is_alu     = is_flag_op || cmd.op inside {dmb_pkg::OP_NIBBLE_SWAP, dmb_pkg::OP_FLAG_DEPOSIT_BIT};
    two_cyc    = is_load || is_store || cmd.op inside {dmb_pkg::OP_IO_BIT_RAISE, dmb_pkg::OP_IO_BIT_DROP};
    pre_dec    = is_ptr && cmd.mode == dmb_pkg::MODE_PRE_DEC;
    post_inc   = is_ptr && cmd.mode == dmb_pkg::MODE_POST_INC;
  end

  // Pointers are fixed register pairs, updated as one 16-bit value
  logic [4:0]  ptr_lo;
  logic [15:0] ptr_val, mem_addr;
  logic [7:0]  rsrc, dmem_rd;
  logic [DAW-1:0] dmem_idx;
  logic [IOW-1:0] io_idx;
  always_comb begin
    case (cmd.ptr)
      dmb_pkg::PTR_Y: ptr_lo = `DMB_PTR_Y_LO;
      dmb_pkg::PTR_Z: ptr_lo = `DMB_PTR_Z_LO;
      default:        ptr_lo = `DMB_PTR_X_LO;
    endcase
  end
  assign ptr_val = {gpr_q[ptr_lo + 5'h01], gpr_q[ptr_lo]};
  assign rsrc    = gpr_q[cmd.rsel];

  always_comb begin
    case (cmd.op)
      dmb_pkg::OP_LOAD_OFFSET, dmb_pkg::OP_SAVE_OFFSET:     mem_addr = ptr_val + {10'h000, cmd.disp};
      dmb_pkg::OP_LOAD_ABSOLUTE, dmb_pkg::OP_SAVE_ABSOLUTE: mem_addr = cmd.addr;
      dmb_pkg::OP_STACK_PUT, dmb_pkg::OP_STACK_TAKE:       mem_addr = sp_q;
      default:                                             mem_addr = ptr_val;
    endcase
  end
  // The data space aliases modulo the memory depth
  assign dmem_idx = mem_addr[DAW-1:0];
  assign dmem_rd  = dmem_q[dmem_idx];
  assign io_idx   = cmd.addr[IOW-1:0];

  // Shift, rotate and bit datapath
  logic [7:0] alu_res;
  logic       alu_c;
  always_comb begin
    alu_res = rsrc;
    alu_c   = status_q[`DMB_FLAG_C];
    case (cmd.op)
      dmb_pkg::OP_SHIFT_UP_LOGICAL: begin
        alu_res = {rsrc[6:0], 1'b0};
        alu_c   = rsrc[7];
      end
      dmb_pkg::OP_SHIFT_DOWN_LOGICAL: begin
        alu_res = {1'b0, rsrc[7:1]};
        alu_c   = rsrc[0];
      end
      dmb_pkg::OP_ROTATE_UP_CARRY: begin
        alu_res = {rsrc[6:0], status_q[`DMB_FLAG_C]};
        alu_c   = rsrc[7];
      end
      dmb_pkg::OP_ROTATE_DOWN_CARRY: begin
        alu_res = {status_q[`DMB_FLAG_C], rsrc[7:1]};
        alu_c   = rsrc[0];
      end
      dmb_pkg::OP_SHIFT_DOWN_SIGNED: begin
        alu_res = {rsrc[7], rsrc[7:1]};
        alu_c   = rsrc[0];
      end
      dmb_pkg::OP_NIBBLE_SWAP:      alu_res = {rsrc[3:0], rsrc[7:4]};
      dmb_pkg::OP_FLAG_DEPOSIT_BIT: alu_res[cmd.bsel] = status_q[`DMB_FLAG_T];
      default: ;
    endcase
  end

  // Sequencer: single-cycle work in EX1, memory work in EX2
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_q <= dmb_pkg::ST_IDLE;
    end else begin
      case (state_q)
        dmb_pkg::ST_IDLE: if (launch) state_q <= dmb_pkg::ST_EX1;
        dmb_pkg::ST_EX1:  state_q <= two_cyc ? dmb_pkg::ST_EX2 : dmb_pkg::ST_IDLE;
        default:          state_q <= dmb_pkg::ST_IDLE;
      endcase
    end
  end

  // Register file; a post-increment update wins over a load into the same pair, a pre-decrement update loses to it
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      for (int i = 0; i < NREG; i++) gpr_q[i] <= 8'h00;
    end else begin
      if (wr && hit_gpr && avs_byteenable[0]) gpr_q[ofs_gpr[RW+1:2]] <= avs_writedata[7:0];
      if (state_q == dmb_pkg::ST_EX1) begin
        if (is_alu) gpr_q[cmd.rsel] <= alu_res;
        if (pre_dec) {gpr_q[ptr_lo + 5'h01], gpr_q[ptr_lo]} <= ptr_val - 16'h0001;
      end
      if (state_q == dmb_pkg::ST_EX2) begin
        if (is_load) gpr_q[cmd.rsel] <= dmem_rd;
        if (post_inc) {gpr_q[ptr_lo + 5'h01], gpr_q[ptr_lo]} <= ptr_val + 16'h0001;
      end
    end
  end

  // Data memory has no reset; contents are undefined until written
  always_ff @(posedge clk) begin
    if (wr && hit_dmem && avs_byteenable[0]) dmem_q[ofs_dmem[DAW+1:2]] <= avs_writedata[7:0];
    if (state_q == dmb_pkg::ST_EX2 && is_store) dmem_q[dmem_idx] <= rsrc;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      for (int i = 0; i < IO_DEPTH; i++) io_q[i] <= 8'h00;
    end else begin
      if (wr && hit_io && avs_byteenable[0]) io_q[ofs_io[IOW+1:2]] <= avs_writedata[7:0];
      if (state_q == dmb_pkg::ST_EX2 && cmd.op == dmb_pkg::OP_IO_BIT_RAISE) io_q[io_idx][cmd.bsel] <= 1'b1;
      if (state_q == dmb_pkg::ST_EX2 && cmd.op == dmb_pkg::OP_IO_BIT_DROP) io_q[io_idx][cmd.bsel] <= 1'b0;
    end
  end

  // Stack grows downward: put writes then decrements, take increments then reads
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sp_q <= `DMB_SP_RST;
    end else if (wr && avs_address == `DMB_OFS_SP) begin
      if (avs_byteenable[0]) sp_q[7:0] <= avs_writedata[7:0];
      if (avs_byteenable[1]) sp_q[15:8] <= avs_writedata[15:8];
    end else if (state_q == dmb_pkg::ST_EX1 && cmd.op == dmb_pkg::OP_STACK_TAKE) begin
      sp_q <= sp_q + 16'h0001;
    end else if (state_q == dmb_pkg::ST_EX2 && cmd.op == dmb_pkg::OP_STACK_PUT) begin
      sp_q <= sp_q - 16'h0001;
    end
  end

  // Status flags change only on a STAT write and for shifts, rotates and bit capture
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      status_q <= `DMB_STAT_RST;
    end else if (wr && avs_address == `DMB_OFS_STAT && avs_byteenable[0]) begin
      status_q <= avs_writedata[7:0];
    end else if (state_q == dmb_pkg::ST_EX1 && is_flag_op) begin
      status_q[`DMB_FLAG_C] <= alu_c;
      status_q[`DMB_FLAG_N] <= alu_res[7];
      status_q[`DMB_FLAG_V] <= alu_res[7] ^ alu_c;
      status_q[`DMB_FLAG_Z] <= (alu_res == 8'h00);
    end else if (state_q == dmb_pkg::ST_EX1 && cmd.op == dmb_pkg::OP_FLAG_CAPTURE_BIT) begin
      status_q[`DMB_FLAG_T] <= rsrc[cmd.bsel];
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic rsel_in_ptr;
  assign rsel_in_ptr = (cmd.rsel[4:1] == ptr_lo[4:1]);

  a_ld_post_inc: assert property ((state_q == dmb_pkg::ST_EX2) && is_load && post_inc && !rsel_in_ptr
    |=> (gpr_q[cmd.rsel] == $past(dmem_rd)) && (ptr_val == $past(ptr_val) + 16'h0001))
    else $error("post-increment load wrong");
  a_ld_pre_dec: assert property ((state_q == dmb_pkg::ST_EX1) && is_load && pre_dec && !rsel_in_ptr
    |=> (ptr_val == $past(ptr_val) - 16'h0001) ##1 (gpr_q[cmd.rsel] == $past(dmem_rd)))
    else $error("pre-decrement load wrong");
  a_mem_length: assert property ((state_q == dmb_pkg::ST_EX1) && two_cyc
    |=> (state_q == dmb_pkg::ST_EX2) ##1 (state_q == dmb_pkg::ST_IDLE))
    else $error("memory operation not two cycles");
  a_offset_keep: assert property ((state_q == dmb_pkg::ST_EX2) && cmd.op inside {dmb_pkg::OP_LOAD_OFFSET,
    dmb_pkg::OP_SAVE_OFFSET} && !rsel_in_ptr |-> (mem_addr == ptr_val + {10'h000, cmd.disp}) ##1 $stable(ptr_val))
    else $error("offset access wrong");
  a_abs_load: assert property ((state_q == dmb_pkg::ST_EX2) && cmd.op == dmb_pkg::OP_LOAD_ABSOLUTE
    |-> (dmem_idx == cmd.addr[DAW-1:0]) ##1 (gpr_q[cmd.rsel] == $past(dmem_rd)))
    else $error("absolute load wrong");
  a_store_data: assert property ((state_q == dmb_pkg::ST_EX2) && is_store
    |=> dmem_q[$past(dmem_idx)] == $past(rsrc))
    else $error("store data wrong");
  a_stack_put: assert property ((state_q == dmb_pkg::ST_EX2) && cmd.op == dmb_pkg::OP_STACK_PUT
    |=> (sp_q == $past(sp_q) - 16'h0001) && $stable(status_q))
    else $error("stack put wrong");
  a_stack_take: assert property ((state_q == dmb_pkg::ST_EX1) && cmd.op == dmb_pkg::OP_STACK_TAKE
    |=> (sp_q == $past(sp_q) + 16'h0001) ##1 (gpr_q[cmd.rsel] == $past(dmem_rd)))
    else $error("stack take wrong");
  a_io_raise: assert property ((state_q == dmb_pkg::ST_EX2) && cmd.op == dmb_pkg::OP_IO_BIT_RAISE
    |=> io_q[$past(io_idx)] == ($past(io_q[io_idx]) | (8'h01 << $past(cmd.bsel))))
    else $error("I/O bit raise wrong");
  a_shift_left: assert property ((state_q == dmb_pkg::ST_EX1) && cmd.op == dmb_pkg::OP_SHIFT_UP_LOGICAL
    |=> (gpr_q[cmd.rsel] == {$past(rsrc[6:0]), 1'b0}) && (status_q[`DMB_FLAG_C] == $past(rsrc[7])))
    else $error("left shift wrong");
  a_rot_right: assert property ((state_q == dmb_pkg::ST_EX1) && cmd.op == dmb_pkg::OP_ROTATE_DOWN_CARRY
    |=> gpr_q[cmd.rsel] == {$past(status_q[`DMB_FLAG_C]), $past(rsrc[7:1])})
    else $error("right rotate wrong");
  a_swap_flags: assert property ((state_q == dmb_pkg::ST_EX1) && cmd.op == dmb_pkg::OP_NIBBLE_SWAP
    |=> (gpr_q[cmd.rsel] == {$past(rsrc[3:0]), $past(rsrc[7:4])}) && $stable(status_q) && (state_q == dmb_pkg::ST_IDLE))
    else $error("nibble swap wrong");
  a_bit_capture: assert property ((state_q == dmb_pkg::ST_EX1) && cmd.op == dmb_pkg::OP_FLAG_CAPTURE_BIT
    |=> status_q[`DMB_FLAG_T] == $past(rsrc[cmd.bsel]))
    else $error("bit capture wrong");
  a_xfer_flags: assert property ((state_q != dmb_pkg::ST_IDLE) && two_cyc |=> $stable(status_q))
    else $error("transfer changed flags");

  c_post_inc: cover property ((state_q == dmb_pkg::ST_EX2) && is_load && post_inc);
  c_stack_put: cover property ((state_q == dmb_pkg::ST_EX2) && cmd.op == dmb_pkg::OP_STACK_PUT);
  c_rotate: cover property ((state_q == dmb_pkg::ST_EX1) && cmd.op == dmb_pkg::OP_ROTATE_UP_CARRY);
endmodule // dmb_core

// ==== sim/dmb_host.sv ====
// Avalon-MM master standing in for the software side of the unit
`timescale 1ns/100ps
module dmb_host (
  input  wire logic        clk,             // Core clock
  input  wire logic        avs_waitrequest, // Stall from the unit
  output logic      [15:0] avs_address,     // Byte address
  output logic             avs_read,        // Read request
  output logic             avs_write,       // Write request
  output logic      [31:0] avs_writedata,   // Write data
  output logic      [3:0]  avs_byteenable,  // Byte lanes
  output logic             hang             // High once an answer never came
);
  initial begin
    avs_address    = 16'h0000;
    avs_read       = 1'b0;
    avs_write      = 1'b0;
    avs_writedata  = 32'h0000_0000;
    avs_byteenable = 4'hf;
    hang           = 1'b0;
  end

  // Request held steady until waitrequest is sampled low or 64 cycles pass; released at that edge
  task automatic xfer(input logic wr, input logic [15:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    avs_address   <= a;
    avs_write     <= wr;
    avs_read      <= ~wr;
    avs_writedata <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 64);
    if (avs_waitrequest !== 1'b0) hang <= 1'b1;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask
endmodule // dmb_host

// ==== sim/dmb_core_tb.sv ====
// Self-checking bench of the data-move and bit unit
`timescale 1ns/100ps
`include "dmb_defs.svh"
module dmb_core_tb;
  logic        clk;
  logic        rst_b;
  logic [15:0] avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        hang;
  int          bad_count;
  int          check_count;
  logic [31:0] exp_q[$];
  logic [31:0] seed;

  dmb_core u_dmb_core (.clk(clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  dmb_host u_dmb_host (.clk(clk), .avs_waitrequest(avs_waitrequest), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .hang(hang));

  initial clk = 1'b0;
  always #4 clk = ~clk;

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    check_count++;
    if (seen !== want) begin
      bad_count++;
      $display("ERROR t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  task automatic end_of_test();
    $display("bad_count=%0d check_count=%0d", bad_count, check_count);
    if (bad_count == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  function automatic logic [7:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction

  // Each answered read is judged against the oldest note
  always @(posedge clk) begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
      if (exp_q.size() == 0) check(avs_readdata, 32'hdead_beef);
      else check(avs_readdata, exp_q.pop_front());
    end
  end

  always @(posedge hang) begin
    bad_count++;
    end_of_test();
  end

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    u_dmb_host.xfer(1'b1, a, {24'h0, d});
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    exp_q.push_back({24'h0, e});
    u_dmb_host.xfer(1'b0, a, 32'h0);
  endtask

  function automatic logic [15:0] gpr(input int n);
    return `DMB_OFS_GPR + 16'(4 * n);
  endfunction

  function automatic logic [15:0] mem(input int n);
    return `DMB_OFS_DMEM + 16'(4 * n);
  endfunction

  // Argument word goes first, the command write launches the operation
  task automatic run(input int op, input int r, input int b, input int p, input int m, input int dsp,
                     input logic [15:0] arg);
    dmb_pkg::dmb_cmd_t c;
    c.addr = arg;
    c.disp = 6'(dsp);
    c.mode = dmb_pkg::dmb_mode_t'(m);
    c.ptr  = dmb_pkg::dmb_ptr_t'(p);
    c.bsel = 3'(b);
    c.rsel = 5'(r);
    c.op   = dmb_pkg::dmb_op_t'(op);
    u_dmb_host.xfer(1'b1, `DMB_OFS_ARG, {16'h0, c.addr});
    u_dmb_host.xfer(1'b1, `DMB_OFS_CMD, {9'h0, c[22:0]});
  endtask

  initial begin
    logic [15:0] pv;
    logic [15:0] ea;
    logic [15:0] nv;
    logic [7:0]  v;
    logic [7:0]  s;
    logic [7:0]  res;
    logic [7:0]  t8;
    logic        cy;
    int          op;
    rst_b = 1'b0;
    seed = 32'h6af036fb;
    bad_count = 0;
    check_count = 0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    rd(`DMB_OFS_SP, 8'h7f);
    rd(`DMB_OFS_STAT, 8'h00);
    wr(16'h0300, 8'hff);
    rd(16'h0300, 8'h00);
    s = xs();
    wr(`DMB_OFS_STAT, s);
    // Post-increment and pre-decrement straddle a byte boundary of the pointer
    for (int p = 0; p < 3; p++) for (int m = 0; m < 3; m++) for (int w = 0; w < 2; w++) begin
      pv = (m == 1) ? 16'h00ff : (m == 2) ? 16'h0100 : 16'h0040;
      ea = (m == 2) ? pv - 16'h1 : pv;
      nv = (m == 1) ? pv + 16'h1 : ea;
      v = xs();
      wr(gpr(26 + 2 * p), pv[7:0]);
      wr(gpr(27 + 2 * p), pv[15:8]);
      if (w == 1) begin
        wr(gpr(3), v);
        run(4, 3, 0, p, m, 0, 16'h0);
        rd(mem(int'(ea[6:0])), v);
      end else begin
        wr(mem(int'(ea[6:0])), v);
        run(1, 2, 0, p, m, 0, 16'h0);
        rd(gpr(2), v);
      end
      rd(gpr(26 + 2 * p), nv[7:0]);
      rd(gpr(27 + 2 * p), nv[15:8]);
    end
    for (int p = 1; p < 3; p++) begin
      v = xs();
      wr(gpr(26 + 2 * p), 8'h30);
      wr(gpr(27 + 2 * p), 8'h00);
      wr(mem(16'h6f), v);
      run(2, 11, 0, p, 0, 63, 16'h0);
      rd(gpr(11), v);
      wr(gpr(12), ~v);
      run(5, 12, 0, p, 0, 63, 16'h0);
      rd(mem(16'h6f), ~v);
      rd(gpr(26 + 2 * p), 8'h30);
    end
    v = xs();
    wr(mem(5), v);
    run(3, 9, 0, 0, 0, 0, 16'h0105);
    rd(gpr(9), v);
    wr(gpr(10), ~v);
    run(6, 10, 0, 0, 0, 0, 16'h0105);
    rd(mem(5), ~v);
    v = xs();
    wr(gpr(4), v);
    run(7, 4, 0, 0, 0, 0, 16'h0);
    rd(mem(127), v);
    rd(`DMB_OFS_SP, 8'h7e);
    run(8, 5, 0, 0, 0, 0, 16'h0);
    rd(gpr(5), v);
    rd(`DMB_OFS_SP, 8'h7f);
    rd(`DMB_OFS_STAT, s);
    for (int b = 0; b < 8; b++) begin
      v = xs();
      wr(`DMB_OFS_IO + 16'hfc, v);
      run(9, 0, b, 0, 0, 0, 16'd63);
      rd(`DMB_OFS_IO + 16'hfc, v | (8'h01 << b));
      run(10, 0, b, 0, 0, 0, 16'd63);
      rd(`DMB_OFS_IO + 16'hfc, v & ~(8'h01 << b));
    end
    for (int i = 0; i < 15; i++) begin
      op = 11 + i % 5;
      v = (i < 5) ? 8'h80 : xs();
      s = xs();
      cy = s[0];
      wr(`DMB_OFS_STAT, s);
      wr(gpr(6), v);
      run(op, 6, 0, 0, 0, 0, 16'h0);
      case (op)
        11: res = {v[6:0], 1'b0};
        12: res = {1'b0, v[7:1]};
        13: res = {v[6:0], cy};
        14: res = {cy, v[7:1]};
        default: res = {v[7], v[7:1]};
      endcase
      s[0] = (op == 11 || op == 13) ? v[7] : v[0];
      s[1] = (res == 8'h00);
      s[2] = res[7];
      s[3] = res[7] ^ s[0];
      rd(gpr(6), res);
      rd(`DMB_OFS_STAT, s);
    end
    v = xs();
    wr(gpr(7), v);
    run(16, 7, 0, 0, 0, 0, 16'h0);
    rd(gpr(7), {v[3:0], v[7:4]});
    rd(`DMB_OFS_STAT, s);
    v = {v[3:0], v[7:4]};
    t8 = xs();
    wr(gpr(8), t8);
    for (int b = 0; b < 8; b++) begin
      run(17, 7, b, 0, 0, 0, 16'h0);
      s[6] = v[b];
      rd(`DMB_OFS_STAT, s);
      run(18, 8, 7 - b, 0, 0, 0, 16'h0);
      t8[7 - b] = s[6];
      rd(gpr(8), t8);
    end
    rd(`DMB_OFS_STAT, s);
    @(posedge clk);
    if (exp_q.size() != 0) bad_count++;
    end_of_test();
  end
endmodule // dmb_core_tb
